//--- dpcfg_params.svh
// datapath configuration register constants: offsets, fields, reset values
// assumes inclusion by bare name from the design and bench files
`ifndef DPCFG_PARAMS_SVH
`define DPCFG_PARAMS_SVH
`define DPCFG_CONFIG_INDEX   8'h22
`define DPCFG_CONFIG_ADDR    10'h088
`define DPCFG_ADDR_W         10
`define DPCFG_CONFIG_RESET   8'h00
`define DPCFG_BIT_BLOCK      7
`define DPCFG_BIT_PASS       6
`define DPCFG_BIT_POL        5
`define DPCFG_BIT_AUXSUP     4
`define DPCFG_BIT_QUADOVR    3
`define DPCFG_BIT_18BIT      2
`define DPCFG_BIT_INBAND     1
`define DPCFG_BIT_QUAD       0
`define DPCFG_FWD_MASK       8'h7F
`endif

//--- dpcfg_pkg.sv
// types for the datapath configuration register block
// assumes dpcfg_params.svh is on the include path
package dpcfg_pkg;
	typedef enum logic [1:0] {
		DPCFG_IDLE = 2'b00,
		DPCFG_ACK  = 2'b01
	} dpcfg_bus_t;
endpackage

//--- dpcfg_regs.sv
// datapath configuration register with wishbone slave and forward-channel load port
// assumes a classic wishbone master on clk_i and forward loads as one-cycle strobes
// Functional notes
// R1 - override bit set: forward-channel loads ignored; clear: loads allowed.
// R2 - bits 6..0 load from remote transmitter unless override bit set.
// R3 - bit 6 set forwards pixels regardless of valid strobe.
// R4 - strobe-independent forwarding disables content protection and blocks packetized audio.
// R5 - bit 5 selects strobe polarity: 1 active low, 0 active high.
// R6 - bit 4 set suppresses packetized audio on pixel outputs.
// R7 - bit 3 set takes four-lane enable from bit 0; clear disables it.
// R8 - bit 2 set selects 18-bit colour, clear 24-bit.
// R9 - bit 1 set selects in-band audio, clear data-island.
// R10 - bit 0 enables four-lane audio output.
// R11 - local write immediate; forward load never changes override bit.
//
// The Wishbone register port was chosen for this implementation.
`include "dpcfg_params.svh"
module dpcfg_regs #(
	parameter int ADDR_W = `DPCFG_ADDR_W,
	parameter int DATA_W = 32
) (
	// clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// wishbone slave
	input  wire logic                cyc_i,
	input  wire logic                stb_i,
	input  wire logic                we_i,
	input  wire logic [ADDR_W-1:0]   adr_i,
	input  wire logic [DATA_W/8-1:0] sel_i,
	input  wire logic [DATA_W-1:0]   dat_i,
	output logic      [DATA_W-1:0]   dat_o,
	output logic                     ack_o,
	// forward-channel load
	input  wire logic                fwd_load_i,
	input  wire logic [7:0]          fwd_data_i,
	// raw pixel valid strobe
	input  wire logic                pixel_valid_strobe_i,
	// datapath controls
	output logic                     pixel_gate_o,
	output logic                     content_prot_en_o,
	output logic                     aux_on_pixel_en_o,
	output logic                     color_18bit_o,
	output logic                     audio_inband_o,
	output logic                     quad_audio_en_o,
	output logic      [7:0]          config_o
);
	typedef struct packed {
		logic [7:0]            cfg;
		dpcfg_pkg::dpcfg_bus_t bus;
		logic                  ack;
		logic [DATA_W-1:0]     rdat;
		logic                  gate;
		logic                  cp;
		logic                  aux;
		logic                  b18;
		logic                  inb;
		logic                  quad;
	} dpcfg_state_t;

	dpcfg_state_t st_reg;
	dpcfg_state_t st_next;

	// the offset needs eight address bits and the register one full byte lane
	if (ADDR_W < 8 || ADDR_W > 32) begin : g_addr_w_check
		$error("address width cannot hold the register offset");
	end
	if (DATA_W < 8 || DATA_W > 64 || (DATA_W % 8) != 0) begin : g_data_w_check
		$error("data width must be whole bytes from 8 to 64");
	end

	function automatic logic hit(input logic [ADDR_W-1:0] a);
		hit = (a == ADDR_W'(`DPCFG_CONFIG_ADDR));
	endfunction

	logic       req;
	logic       rd_hit;
	logic       wr_hit;
	logic [7:0] cfg_mid;
	// a request is taken only while idle, so a held strobe is not answered twice
	assign req = cyc_i && stb_i && (st_reg.bus == dpcfg_pkg::DPCFG_IDLE);
	assign rd_hit = req && !we_i && hit(adr_i);
	assign wr_hit = req && we_i && hit(adr_i) && sel_i[0];

	always_comb begin
		st_next = st_reg;
		cfg_mid = st_reg.cfg;
		// forward load first so a same-cycle local write wins
		if (fwd_load_i && !st_reg.cfg[`DPCFG_BIT_BLOCK]) begin // [R1] [R2]
			cfg_mid = (st_reg.cfg & ~`DPCFG_FWD_MASK) | (fwd_data_i & `DPCFG_FWD_MASK); // [R11]
		end
		if (wr_hit) begin
			cfg_mid = dat_i[7:0]; // [R11]
		end
		st_next.cfg = cfg_mid;
		// ack stands for one cycle, then the slave is idle again
		case (st_reg.bus)
			dpcfg_pkg::DPCFG_IDLE: begin
				if (req) begin
					st_next.bus = dpcfg_pkg::DPCFG_ACK;
				end
			end
			dpcfg_pkg::DPCFG_ACK: begin
				st_next.bus = dpcfg_pkg::DPCFG_IDLE;
			end
			default: begin
				st_next.bus = dpcfg_pkg::DPCFG_IDLE;
			end
		endcase
		st_next.ack = req;
		// read data is zero outside the ack cycle so a bus or-tree stays clean
		st_next.rdat = '0;
		if (rd_hit) begin
			st_next.rdat = DATA_W'(st_reg.cfg);
		end
		// pixel gate: polarity-corrected strobe, or open when pass-through
		st_next.gate = st_reg.cfg[`DPCFG_BIT_PASS] |
			(pixel_valid_strobe_i ^ st_reg.cfg[`DPCFG_BIT_POL]); // [R3] [R5]
		// unframed pixels cannot carry protection or audio packets safely
		st_next.cp = !st_reg.cfg[`DPCFG_BIT_PASS]; // [R4]
		st_next.aux = !st_reg.cfg[`DPCFG_BIT_AUXSUP] && !st_reg.cfg[`DPCFG_BIT_PASS]; // [R4] [R6]
		st_next.b18 = st_reg.cfg[`DPCFG_BIT_18BIT]; // [R8]
		st_next.inb = st_reg.cfg[`DPCFG_BIT_INBAND]; // [R9]
		st_next.quad = st_reg.cfg[`DPCFG_BIT_QUADOVR] && st_reg.cfg[`DPCFG_BIT_QUAD]; // [R7] [R10]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg <= '0;
			st_reg.cfg <= `DPCFG_CONFIG_RESET;
			// derived paths come up as a cleared register would drive them
			st_reg.cp <= 1'b1;
			st_reg.aux <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs are flop bits with no logic after them
	assign dat_o = st_reg.rdat;
	assign ack_o = st_reg.ack;
	assign pixel_gate_o = st_reg.gate;
	assign content_prot_en_o = st_reg.cp;
	assign aux_on_pixel_en_o = st_reg.aux;
	assign color_18bit_o = st_reg.b18;
	assign audio_inband_o = st_reg.inb;
	assign quad_audio_en_o = st_reg.quad;
	assign config_o = st_reg.cfg;

	// register content
	a_block_holds: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
		(st_reg.cfg[7] && fwd_load_i && !wr_hit) |=> $stable(st_reg.cfg))
		else $error("forward load changed blocked register");
	a_fwd_loads: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
		(!st_reg.cfg[7] && fwd_load_i && !wr_hit) |=>
		(st_reg.cfg[6:0] == $past(fwd_data_i[6:0])))
		else $error("forward load not taken");
	a_fwd_keeps_ovr: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
		(fwd_load_i && !wr_hit) |=> (st_reg.cfg[7] == $past(st_reg.cfg[7])))
		else $error("forward load changed override bit");
	a_local_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
		wr_hit |=> (st_reg.cfg == $past(dat_i[7:0])))
		else $error("local write not taken");
	a_no_event_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
		(!fwd_load_i && !(cyc_i && stb_i && !ack_o && we_i)) |=> $stable(config_o))
		else $error("register changed with no load or write");
	a_lane_refused: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
		(cyc_i && stb_i && !ack_o && we_i && !sel_i[0] && !fwd_load_i) |=> $stable(config_o))
		else $error("write without byte lane 0 changed register");
	a_reset_state: assert property (@(posedge clk_i) // [R1]
		rst_i |=> (config_o == `DPCFG_CONFIG_RESET && !ack_o && content_prot_en_o))
		else $error("state after reset wrong");

	// derived controls, one edge behind the register
	a_pass_gate: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
		st_reg.cfg[6] |=> pixel_gate_o)
		else $error("pass-through did not open gate");
	a_pol_gate: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
		!st_reg.cfg[6] |=>
		(pixel_gate_o == ($past(pixel_valid_strobe_i) ^ $past(st_reg.cfg[5]))))
		else $error("strobe polarity wrong");
	a_pass_blocks: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
		st_reg.cfg[6] |=> (!content_prot_en_o && !aux_on_pixel_en_o))
		else $error("pass-through left protection or audio on");
	a_prot_follows: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
		!st_reg.cfg[6] |=> content_prot_en_o)
		else $error("protection off without pass-through");
	a_aux_sup: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
		st_reg.cfg[4] |=> !aux_on_pixel_en_o)
		else $error("audio not suppressed");
	a_aux_out: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
		(!st_reg.cfg[4] && !st_reg.cfg[6]) |=> aux_on_pixel_en_o)
		else $error("audio suppressed with both bits clear");
	a_quad_gate: assert property (@(posedge clk_i) disable iff (rst_i) // [R7] [R10]
		1'b1 |=> (quad_audio_en_o == ($past(st_reg.cfg[3]) && $past(st_reg.cfg[0]))))
		else $error("four-lane enable wrong");
	a_mode_bits: assert property (@(posedge clk_i) disable iff (rst_i) // [R8] [R9]
		1'b1 |=> (color_18bit_o == $past(st_reg.cfg[2]) &&
		audio_inband_o == $past(st_reg.cfg[1])))
		else $error("colour or transport mode wrong");

	// handshake steps: a request seen while idle, then one ack and back to idle
	sequence s_taken;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_ack_pulse;
		ack_o ##1 !ack_o;
	endsequence
	a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
		s_taken |=> s_ack_pulse)
		else $error("request not answered by a single ack");
	a_ack_unasked: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
		!(cyc_i && stb_i) |=> !ack_o)
		else $error("ack without a request");
	a_read_data: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
		(s_taken ##0 (!we_i && adr_i == ADDR_W'(`DPCFG_CONFIG_ADDR))) |=>
		(dat_o == DATA_W'($past(config_o))))
		else $error("read data does not match register");
	a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
		(s_taken ##0 (!we_i && adr_i != ADDR_W'(`DPCFG_CONFIG_ADDR))) |=> (dat_o == '0))
		else $error("unmapped read not zero");
	a_idle_data: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
		!ack_o |-> (dat_o == '0))
		else $error("read data stands without ack");
endmodule

//--- dpcfg_fwd_model.sv
// remote transmitter model: forward-channel loads as one-cycle strobes
// assumes send is called just after a rising edge of clk_i
module dpcfg_fwd_model (
	input  wire logic       clk_i,
	output logic            fwd_load_o,
	output logic [7:0]      fwd_data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		fwd_load_o = 1'b0;
		fwd_data_o = 8'h00;
	end
	// released data shows the inverse, so a stale value is never mistaken
	task automatic send(input logic [7:0] v);
		fwd_load_o <= 1'b1;
		fwd_data_o <= v;
		@(posedge clk_i);
		fwd_load_o <= 1'b0;
		fwd_data_o <= ~v;
	endtask
endmodule

//--- dpcfg_regs_bench.sv
// bench for the datapath configuration register
// assumes dpcfg_regs and dpcfg_fwd_model are compiled first
`include "dpcfg_params.svh"
module dpcfg_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, pvs = 1'b0;
	logic [9:0] adr = 10'h000;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0, rdat, q;
	logic ack, fl, gate, cp, aux, c18, inb, quad;
	logic [7:0] fd, cfg;
	int miscompares = 0, checks = 0;
	always #20 clk = ~clk;
	dpcfg_fwd_model fm (.clk_i(clk), .fwd_load_o(fl), .fwd_data_o(fd));
	dpcfg_regs dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
		.fwd_load_i(fl), .fwd_data_i(fd), .pixel_valid_strobe_i(pvs),
		.pixel_gate_o(gate), .content_prot_en_o(cp), .aux_on_pixel_en_o(aux),
		.color_18bit_o(c18), .audio_inband_o(inb), .quad_audio_en_o(quad),
		.config_o(cfg));
	task automatic close_out;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// hold the request until ack is sampled; no latency assumed
	task automatic bus(input logic w, input logic [9:0] a, input logic [3:0] s,
			input logic [31:0] d);
		int i;
		i = 0;
		{cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
		do begin
			@(posedge clk);
			i++;
		end while (ack !== 1'b1 && i < 20);
		if (ack !== 1'b1) begin
			miscompares++;
			close_out;
		end else begin
			q = rdat;
			{cyc, stb} <= 2'b00;
			@(posedge clk);
		end
	endtask
	// derived outputs lag the register by one cycle
	task automatic set(input logic [7:0] v, input logic [5:0] e);
		bus(1'b1, `DPCFG_CONFIG_ADDR, 4'hF, {24'h0, v});
		repeat (2) @(posedge clk);
		chk("config", {24'h0, v}, {24'h0, cfg});
		chk("controls", {26'h0, e}, {26'h0, gate, cp, aux, c18, inb, quad});
	endtask
	task automatic fwd(input logic [7:0] v, input logic [7:0] e);
		fm.send(v);
		repeat (2) @(posedge clk);
		chk("forward load", {24'h0, e}, {24'h0, cfg});
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		bus(1'b0, `DPCFG_CONFIG_ADDR, 4'hF, 32'h0);
		chk("reset read", 32'h0, q);
		chk("reset ctl", 32'h18, {26'h0, gate, cp, aux, c18, inb, quad});
		set(8'h20, 6'h38);
		set(8'h40, 6'h20);
		pvs <= 1'b1;
		set(8'h20, 6'h18);
		set(8'h00, 6'h38);
		set(8'h50, 6'h20);
		set(8'h0D, 6'h3D);
		set(8'h07, 6'h3E);
		set(8'h08, 6'h38);
		set(8'h10, 6'h30);
		$display("field test done");
		fwd(8'hFF, 8'h7F);
		set(8'h80, 6'h38);
		fwd(8'h55, 8'h80);
		bus(1'b0, `DPCFG_CONFIG_ADDR, 4'hF, 32'h0);
		chk("read back", 32'h80, q);
		set(8'h00, 6'h38);
		fwd(8'hD5, 8'h55);
		$display("forward test done");
		bus(1'b1, `DPCFG_CONFIG_ADDR, 4'hE, 32'h33);
		chk("no lane 0", 32'h55, {24'h0, cfg});
		bus(1'b0, 10'h084, 4'hF, 32'h0);
		chk("unmapped read", 32'h0, q);
		$display("refusal test done");
		close_out;
	end
endmodule
